// [rtl/dafs_pkg.sv]
// Shared constants and carrier types for DTE speed and format sensing
package dafs_pkg;
    // Core clock rate in hertz (period 8 ns)
    localparam int unsigned CLK_HZ_DEF = 125_000_000;
    localparam int unsigned CLK_PERIOD_NS = 8;
    // Host bit rates that can be sensed, slowest first
    localparam int RATE_N = 18;
    localparam int unsigned RATE_BPS [RATE_N] = '{
        300, 600, 1200, 2400, 4800, 7200, 9600, 12000, 14400,
        16800, 19200, 21600, 24000, 26400, 28800, 38400, 57600, 115200};
    // Fastest rate sensed in fax mode, as a table index
    localparam int unsigned FAX_MAX_BPS = 115200;
    localparam logic [4:0] FAX_TOP_IDX = 5'h11;
    localparam logic [4:0] TOP_IDX = 5'h11;
    // Bit-period counter width and sample positions after the start bit
    localparam int PER_W = 20;
    localparam int MEAS_W = 21;
    localparam int SMP_N = 9;
    localparam logic [3:0] LAST_POS = 4'h8;
    // Shortest transmit frame bit count and frame field positions within the sample vector
    localparam int POS_P7 = 7;
    localparam int POS_P8 = 8;
    localparam logic [3:0] TX_BITS_MIN = 4'h9;
    // Receive state codes, one-hot
    typedef enum logic [5:0] {
        ST_HUNT = 6'h01,
        ST_MEAS = 6'h02,
        ST_SAMP = 6'h04,
        ST_EVAL = 6'h08,
        ST_GAP = 6'h10,
        ST_IDLE = 6'h20
    } dafs_state_e;
    // Serial character format in force
    typedef struct packed {
        logic data8;
        logic par_en;
        logic par_odd;
        logic stop2;
    } dafs_cfg_s;
    localparam dafs_cfg_s CFG_RST = '{data8: 1'b1, par_en: 1'b0, par_odd: 1'b0, stop2: 1'b0};
    // One received character with its checks
    typedef struct packed {
        logic [7:0] data;
        logic parity_err;
        logic frame_err;
    } dafs_rx_s;
endpackage : dafs_pkg

// [rtl/dafs_tx.sv]
// Serial transmitter that frames host-bound characters in the sensed format
`timescale 1ns/1ps
module dafs_tx
    import dafs_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic enable,
    input wire dafs_cfg_s cfg,
    input wire logic [PER_W-1:0] period,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_ready,
    output logic tx_line
);
    logic [11:0] sh_reg;
    logic [3:0] left_reg;
    logic [PER_W-1:0] tmr_reg;
    logic busy_reg;
    logic [11:0] frame;
    logic [3:0] nbits;
    logic pbit;

    // Frame built LSB first: start, data, optional parity, stop bits
    always_comb begin
        pbit = (cfg.data8 ? ^tx_data : ^tx_data[6:0]) ^ cfg.par_odd;
        frame = 12'hfff;
        frame[0] = 1'b0;
        if (cfg.data8) begin
            frame[8:1] = tx_data;
            if (cfg.par_en) begin
                frame[9] = pbit;
            end
        end else begin
            frame[7:1] = tx_data[6:0];
            if (cfg.par_en) begin
                frame[8] = pbit;
            end
        end
        // Whole frame length, so busy holds through the last stop bit
        nbits = TX_BITS_MIN + {3'h0, cfg.data8} + {3'h0, cfg.par_en} + {3'h0, cfg.stop2};
    end

    assign tx_ready = enable && !busy_reg;

    // Bit timing and shifting
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            sh_reg <= 12'hfff;
            left_reg <= 4'h0;
            tmr_reg <= '0;
            busy_reg <= 1'b0;
        end else if (!enable) begin
            sh_reg <= 12'hfff;
            busy_reg <= 1'b0;
        end else if (!busy_reg) begin
            if (tx_valid) begin
                sh_reg <= frame;
                left_reg <= nbits;
                tmr_reg <= period - 20'h0_0001;
                busy_reg <= 1'b1;
            end
        end else if (tmr_reg != '0) begin
            tmr_reg <= tmr_reg - 20'h0_0001;
        end else begin
            sh_reg <= {1'b1, sh_reg[11:1]};
            tmr_reg <= period - 20'h0_0001;
            left_reg <= left_reg - 4'h1;
            if (left_reg == 4'h1) begin
                busy_reg <= 1'b0;
            end
        end
    end

    assign tx_line = sh_reg[0] | !busy_reg;
endmodule : dafs_tx

// [rtl/dafs_autobaud.sv]
// DTE port speed and character format sensing with receiver and transmitter
// Function
// - Serial port only while interface select low
// - Sense every listed rate 300 to 115200
// - Sense 7N2, 7O1, 7E1, 8N1 ten-bit frames
// - Sense 8-bit parity frames, strip parity
// - Map mark and space parity to fixed formats
// - Fax mode senses rates up to 115200
`timescale 1ns/1ps
module dafs_autobaud
    import dafs_pkg::*;
#(
    parameter int unsigned CLK_HZ = CLK_HZ_DEF
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic host_interface_select,
    input wire logic fax_mode,
    input wire logic detect_req,
    input wire logic rx_line,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_ready,
    output logic tx_line,
    output logic rx_valid,
    output dafs_rx_s rx_word,
    output dafs_cfg_s cfg,
    output logic cfg_valid,
    output logic [4:0] rate_idx,
    output logic [PER_W-1:0] rate_period,
    output logic serial_active
);
    // Bit period in clocks for a table entry, rounded to nearest
    function automatic logic [MEAS_W-1:0] per_of(input int i);
        per_of = MEAS_W'((CLK_HZ + RATE_BPS[i] / 2) / RATE_BPS[i]);
    endfunction : per_of

    localparam logic [MEAS_W-1:0] MEAS_MAX = MEAS_W'((CLK_HZ / RATE_BPS[0]) * 3 / 2);
    localparam logic [MEAS_W-1:0] MEAS_MIN = MEAS_W'(CLK_HZ / RATE_BPS[RATE_N-1] / 2);

    dafs_state_e state_reg;
    logic [MEAS_W-1:0] meas_reg;
    logic [PER_W-1:0] cnt_reg;
    logic [3:0] pos_reg;
    logic [SMP_N-1:0] smp_reg;
    logic [SMP_N-1:0] first_reg;
    logic chr_reg;
    logic rx_prev_reg;
    logic fall;
    logic rise;
    logic serial_on;
    logic [4:0] snap_idx;
    dafs_cfg_s cfg_calc;
    logic meas_ok;

    // Serial port active only when parallel host port not selected
    assign serial_on = !host_interface_select;
    assign serial_active = serial_on;
    assign fall = rx_prev_reg && !rx_line;
    assign rise = !rx_prev_reg && rx_line;
    assign meas_ok = (meas_reg >= MEAS_MIN) && (meas_reg <= MEAS_MAX);

    // Nearest table rate to the measured start bit width
    always_comb begin
        logic [MEAS_W-1:0] best_d;
        logic [MEAS_W-1:0] d;
        logic [4:0] top;
        best_d = '1;
        snap_idx = 5'h00;
        d = '0;
        top = fax_mode ? FAX_TOP_IDX : TOP_IDX;
        for (int i = 0; i < RATE_N; i++) begin
            d = (meas_reg > per_of(i)) ? meas_reg - per_of(i) : per_of(i) - meas_reg;
            if ((5'(i) <= top) && (d < best_d)) begin
                best_d = d;
                snap_idx = 5'(i);
            end
        end
    end

    // Format from two characters: bit 7 and bit 8 positions against parity
    always_comb begin
        logic ea;
        logic eb;
        logic fa;
        logic fb;
        ea = ^first_reg[6:0];
        eb = ^smp_reg[6:0];
        fa = ^first_reg[7:0];
        fb = ^smp_reg[7:0];
        cfg_calc = CFG_RST;
        if (first_reg[POS_P7] && smp_reg[POS_P7]) begin
            cfg_calc = '{data8: 1'b0, par_en: 1'b0, par_odd: 1'b0, stop2: 1'b1};
        end else if (first_reg[POS_P7] || smp_reg[POS_P7]) begin
            if (first_reg[POS_P7] == !ea && smp_reg[POS_P7] == !eb) begin
                cfg_calc = '{data8: 1'b0, par_en: 1'b1, par_odd: 1'b1, stop2: 1'b0};
            end else if (first_reg[POS_P7] == ea && smp_reg[POS_P7] == eb) begin
                cfg_calc = '{data8: 1'b0, par_en: 1'b1, par_odd: 1'b0, stop2: 1'b0};
            end
        end else if (!first_reg[POS_P8] && !smp_reg[POS_P8]) begin
            cfg_calc = '{data8: 1'b1, par_en: 1'b1, par_odd: 1'b0, stop2: 1'b0};
        end else if (!(first_reg[POS_P8] && smp_reg[POS_P8])) begin
            if (first_reg[POS_P8] == !fa && smp_reg[POS_P8] == !fb) begin
                cfg_calc = '{data8: 1'b1, par_en: 1'b1, par_odd: 1'b1, stop2: 1'b0};
            end else if (first_reg[POS_P8] == fa && smp_reg[POS_P8] == fb) begin
                cfg_calc = '{data8: 1'b1, par_en: 1'b1, par_odd: 1'b0, stop2: 1'b0};
            end
        end
    end

    // Line edge history
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_prev_reg <= 1'b1;
        end else begin
            rx_prev_reg <= rx_line;
        end
    end

    // Sequencer: measure, sample nine positions, evaluate, wait idle
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= ST_HUNT;
            meas_reg <= '0;
            cnt_reg <= '0;
            pos_reg <= 4'h0;
            smp_reg <= '0;
        end else if (!serial_on || detect_req) begin
            // A sensed format survives a parallel-port spell; resume in idle then
            state_reg <= (cfg_valid && !detect_req) ? ST_IDLE : ST_HUNT;
        end else begin
            unique case (state_reg)
                ST_HUNT: begin
                    meas_reg <= '0;
                    if (fall) begin
                        state_reg <= ST_MEAS;
                    end
                end
                ST_MEAS: begin
                    if (meas_reg != '1) begin
                        meas_reg <= meas_reg + 21'h00_0001;
                    end
                    if (rise) begin
                        if (meas_ok) begin
                            cnt_reg <= PER_W'(per_of(int'(snap_idx)) >> 1);
                            pos_reg <= 4'h0;
                            state_reg <= ST_SAMP;
                        end else begin
                            state_reg <= ST_HUNT;
                        end
                    end
                end
                ST_SAMP: begin
                    if (cnt_reg != '0) begin
                        cnt_reg <= cnt_reg - 20'h0_0001;
                    end else begin
                        smp_reg[pos_reg] <= rx_line;
                        pos_reg <= pos_reg + 4'h1;
                        cnt_reg <= rate_period - 20'h0_0001;
                        if (pos_reg == LAST_POS) begin
                            state_reg <= ST_EVAL;
                        end
                    end
                end
                ST_EVAL: begin
                    state_reg <= ST_GAP;
                end
                ST_GAP: begin
                    if (rx_line) begin
                        state_reg <= ST_IDLE;
                    end
                end
                ST_IDLE: begin
                    if (fall) begin
                        cnt_reg <= rate_period + (rate_period >> 1) - 20'h0_0002;
                        pos_reg <= 4'h0;
                        state_reg <= ST_SAMP;
                    end
                end
                default: begin
                    state_reg <= ST_HUNT;
                end
            endcase
        end
    end

    // Rate capture on a valid start bit
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rate_idx <= 5'h00;
            rate_period <= '0;
        end else if (serial_on && !detect_req && state_reg == ST_MEAS && rise && meas_ok) begin
            rate_idx <= snap_idx;
            rate_period <= PER_W'(per_of(int'(snap_idx)));
        end
    end

    // Format capture after the second character; held until a new request
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg <= CFG_RST;
            cfg_valid <= 1'b0;
            chr_reg <= 1'b0;
            first_reg <= '0;
        end else if (detect_req) begin
            cfg_valid <= 1'b0;
            chr_reg <= 1'b0;
        end else if (serial_on && state_reg == ST_EVAL && !cfg_valid) begin
            if (!chr_reg) begin
                first_reg <= smp_reg;
                chr_reg <= 1'b1;
            end else begin
                cfg <= cfg_calc;
                cfg_valid <= 1'b1;
            end
        end
    end

    // Received character with parity stripped and checked
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_valid <= 1'b0;
            rx_word <= '0;
        end else begin
            rx_valid <= serial_on && !detect_req && state_reg == ST_EVAL && cfg_valid;
            if (state_reg == ST_EVAL && cfg_valid) begin
                rx_word.data <= cfg.data8 ? smp_reg[7:0] : {1'b0, smp_reg[6:0]};
                rx_word.parity_err <= cfg.par_en &&
                    ((cfg.data8 ? (^smp_reg[7:0] ^ smp_reg[8]) : (^smp_reg[6:0] ^ smp_reg[7])) != cfg.par_odd);
                rx_word.frame_err <= cfg.data8 ? (!cfg.par_en && !smp_reg[8])
                    : (cfg.par_en ? !smp_reg[8] : !(smp_reg[7] && smp_reg[8]));
            end
        end
    end

    // Host-bound characters use the sensed rate and format
    dafs_tx u_tx (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .enable(serial_on && cfg_valid),
        .cfg(cfg),
        .period(rate_period),
        .tx_valid(tx_valid),
        .tx_data(tx_data),
        .tx_ready(tx_ready),
        .tx_line(tx_line)
    );

    sequence s_start_ok;
        state_reg == ST_MEAS && rise && meas_ok && serial_on && !detect_req;
    endsequence
    sequence s_sampling;
        state_reg == ST_SAMP;
    endsequence

    // Ready drops with the select at once; line and receive output idle one edge later
    a_parallel_idle: assert property (@(posedge core_clk) disable iff (!rst_b)
        host_interface_select |-> !tx_ready ##1 (tx_line && !rx_valid)) else $error("serial active in parallel mode");
    a_rate_snap: assert property (@(posedge core_clk) disable iff (!rst_b)
        s_start_ok |=> (rate_idx <= TOP_IDX && rate_period == PER_W'(per_of(int'(rate_idx)))) ##1 s_sampling)
        else $error("rate capture wrong");
    a_fax_cap: assert property (@(posedge core_clk) disable iff (!rst_b)
        (s_start_ok and fax_mode) |=> rate_idx <= FAX_TOP_IDX) else $error("fax rate above cap");
    a_seven_format: assert property (@(posedge core_clk) disable iff (!rst_b)
        cfg_valid && !cfg.data8 |-> !(cfg.par_en && cfg.stop2)) else $error("bad 7-bit format");
    a_space_even: assert property (@(posedge core_clk) disable iff (!rst_b)
        state_reg == ST_EVAL && chr_reg && !cfg_valid && !detect_req && serial_on &&
        !first_reg[7] && !smp_reg[7] && !first_reg[8] && !smp_reg[8]
        |=> cfg_valid && cfg.data8 && cfg.par_en && !cfg.par_odd) else $error("space parity not mapped");
    a_strip_parity: assert property (@(posedge core_clk) disable iff (!rst_b)
        rx_valid && cfg.data8 && cfg.par_en |-> rx_word.data == $past(smp_reg[7:0]))
        else $error("parity not stripped");
    a_cfg_held: assert property (@(posedge core_clk) disable iff (!rst_b)
        cfg_valid && !detect_req |=> cfg_valid && $stable(cfg) && $stable(rate_period)) else $error("format changed");
    a_tx_start: assert property (@(posedge core_clk) disable iff (!rst_b)
        tx_valid && tx_ready && rate_period > 20'h0_0002 |=> !tx_line [*2]) else $error("no start bit");
endmodule : dafs_autobaud

// [verif/dafs_host_model.sv]
// Host terminal model that sends serial characters toward the block
`timescale 1ns/1ps
module dafs_host_model (
    input wire logic core_clk,
    output logic host_tx
);
    // Line idles at mark
    initial host_tx = 1'b1;

    // Low level of a set width, then back to idle
    task automatic send_low(input int width);
        @(negedge core_clk);
        host_tx = 1'b0;
        repeat (width) @(negedge core_clk);
        host_tx = 1'b1;
    endtask : send_low

    // Whole character, LSB first; pmode 0 none, 1 odd, 2 even, 3 mark, 4 space
    task automatic send_char(input logic [7:0] ch, input int nbits, input int pmode, input int nstop,
                             input int per);
        logic par;
        par = (nbits == 8) ? ^ch : ^ch[6:0];
        @(negedge core_clk);
        host_tx = 1'b0;
        repeat (per) @(negedge core_clk);
        for (int i = 0; i < nbits; i++) begin
            host_tx = ch[i];
            repeat (per) @(negedge core_clk);
        end
        if (pmode != 0) begin
            host_tx = (pmode == 1) ? ~par : (pmode == 2) ? par : (pmode == 3);
            repeat (per) @(negedge core_clk);
        end
        host_tx = 1'b1;
        repeat (nstop * per) @(negedge core_clk);
    endtask : send_char
endmodule : dafs_host_model

// [verif/dafs_autobaud_bench.sv]
// Self-checking bench for DTE speed and format sensing
`timescale 1ns/1ps
module dafs_autobaud_bench;
    import dafs_pkg::*;
    localparam int unsigned CLK_HZ_TB = 600_000;
    localparam int LIMIT = 60_000;
    localparam int FMT_N = 10;
    localparam int FMT_BITS [FMT_N] = '{7, 7, 7, 8, 8, 8, 7, 7, 8, 8};
    localparam int FMT_PAR [FMT_N] = '{0, 1, 2, 0, 1, 2, 3, 4, 3, 4};
    localparam int FMT_STOP [FMT_N] = '{2, 1, 1, 1, 1, 1, 1, 1, 1, 1};
    localparam logic [3:0] FMT_CFG [FMT_N] = '{4'h1, 4'h6, 4'h4, 4'h8, 4'hE, 4'hC, 4'h1, 4'h8, 4'h8, 4'hC};
    logic core_clk, rst_b, host_interface_select, fax_mode, detect_req, rx_line;
    logic tx_valid, tx_ready, tx_line, rx_valid, cfg_valid, serial_active;
    logic [7:0] tx_data;
    logic [4:0] rate_idx;
    logic [PER_W-1:0] rate_period;
    dafs_rx_s rx_word;
    dafs_cfg_s cfg;
    int num_errors = 0;
    int comparisons = 0;
    int cycles = 0;

    dafs_autobaud #(.CLK_HZ(CLK_HZ_TB)) i_dafs_autobaud (.core_clk(core_clk), .rst_b(rst_b),
        .host_interface_select(host_interface_select), .fax_mode(fax_mode), .detect_req(detect_req),
        .rx_line(rx_line), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .tx_line(tx_line),
        .rx_valid(rx_valid), .rx_word(rx_word), .cfg(cfg), .cfg_valid(cfg_valid), .rate_idx(rate_idx),
        .rate_period(rate_period), .serial_active(serial_active));
    dafs_host_model i_dafs_host_model (.core_clk(core_clk), .host_tx(rx_line));

    // Core clock, 8 ns period
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    // Hang guard
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            num_errors++;
            end_sim();
        end
    end

    // Closing report and verdict
    task automatic end_sim();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_sim

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Bit period in clocks for a table entry, rounded
    function automatic int per_of(input int r);
        return (CLK_HZ_TB + RATE_BPS[r] / 2) / RATE_BPS[r];
    endfunction : per_of

    task automatic pulse_detect();
        @(negedge core_clk);
        detect_req = 1'b1;
        @(negedge core_clk);
        detect_req = 1'b0;
    endtask : pulse_detect

    // Every listed rate from one start bit; fax mode on the upper half
    task automatic rate_sweep();
        for (int r = 0; r < RATE_N; r++) begin
            fax_mode = (r >= 9);
            pulse_detect();
            i_dafs_host_model.send_low(per_of(r));
            repeat (3) @(negedge core_clk);
            check(rate_idx, r);
            check(rate_period, per_of(r));
        end
        fax_mode = 1'b0;
    endtask : rate_sweep

    // Send one character to the host side and check its framing
    task automatic tx_frame(input logic [7:0] d, input logic [3:0] c, input int per);
        int nb;
        logic [7:0] m;
        nb = c[3] ? 8 : 7;
        m = c[3] ? d : {1'b0, d[6:0]};
        @(negedge core_clk);
        tx_data = d;
        tx_valid = 1'b1;
        for (int k = 0; k < 50 && tx_ready !== 1'b1; k++) @(negedge core_clk);
        @(negedge core_clk);
        tx_valid = 1'b0;
        for (int k = 0; k < 50 && tx_line !== 1'b0; k++) @(negedge core_clk);
        repeat (per / 2) @(negedge core_clk);
        check(tx_line, 1'b0);
        for (int i = 0; i < nb; i++) begin
            repeat (per) @(negedge core_clk);
            check(tx_line, m[i]);
        end
        if (c[2]) begin
            repeat (per) @(negedge core_clk);
            check(tx_line, ^m ^ c[1]);
        end
        // Stop bits: line high, transmitter busy until the last one ends
        for (int s = 0; s <= int'(c[0]); s++) begin
            repeat (per) @(negedge core_clk);
            check(tx_line, 1'b1);
            check(tx_ready, 1'b0);
        end
        for (int k = 0; k < 3 * per && tx_ready !== 1'b1; k++) @(negedge core_clk);
        check(tx_ready, 1'b1);
    endtask : tx_frame

    // Sense one host format, then receive and transmit in it
    task automatic run_format(input int f);
        int per;
        per = per_of(10);
        pulse_detect();
        i_dafs_host_model.send_char(8'h41, FMT_BITS[f], FMT_PAR[f], FMT_STOP[f], per);
        i_dafs_host_model.send_char(8'h61, FMT_BITS[f], FMT_PAR[f], FMT_STOP[f], per);
        for (int k = 0; k < 200 && cfg_valid !== 1'b1; k++) @(negedge core_clk);
        check(cfg_valid, 1'b1);
        check(cfg, FMT_CFG[f]);
        fork
            i_dafs_host_model.send_char(8'hC5, FMT_BITS[f], FMT_PAR[f], FMT_STOP[f], per);
            begin
                for (int k = 0; k < 600 && rx_valid !== 1'b1; k++) @(negedge core_clk);
                check(rx_valid, 1'b1);
                check(rx_word.data, (FMT_BITS[f] == 7) ? 8'h45 : 8'hC5);
                if (f < 6) check(rx_word[1:0], 2'h0);
            end
        join
        tx_frame(8'hC5, FMT_CFG[f], per);
    endtask : run_format

    // Parallel select stops the serial link; restart drops the format
    task automatic select_hold();
        logic [4:0] old;
        old = rate_idx;
        host_interface_select = 1'b1;
        tx_valid = 1'b1;
        @(negedge core_clk);
        check(serial_active, 1'b0);
        check(tx_ready, 1'b0);
        i_dafs_host_model.send_low(per_of(0));
        repeat (5) @(negedge core_clk);
        check(tx_line, 1'b1);
        check(rate_idx, old);
        check(cfg_valid, 1'b1);
        tx_valid = 1'b0;
        host_interface_select = 1'b0;
        pulse_detect();
        @(negedge core_clk);
        check(cfg_valid, 1'b0);
        i_dafs_host_model.send_low(3500);
        repeat (5) @(negedge core_clk);
        check(rate_idx, old);
    endtask : select_hold

    // Main sequence
    initial begin
        rst_b = 1'b0;
        host_interface_select = 1'b0;
        fax_mode = 1'b0;
        detect_req = 1'b0;
        tx_valid = 1'b0;
        tx_data = 8'h00;
        repeat (16) @(negedge core_clk);
        check({tx_line, tx_ready, rx_valid, cfg, cfg_valid, rate_idx}, {3'h4, 4'h8, 6'h00});
        check(rate_period, 0);
        rst_b = 1'b1;
        repeat (4) @(negedge core_clk);
        rate_sweep();
        for (int f = 0; f < FMT_N; f++) run_format(f);
        select_hold();
        end_sim();
    end
endmodule : dafs_autobaud_bench
